// file: bench/prog_mem_model.sv
`timescale 1ns/1ps
`include "stack_ctl_defines.svh"

module prog_mem_model (
  // Clock
  input wire logic clk_i,
  // Core memory side
  input wire logic [`WORD_W-1:0] mem_addr_i,
  input wire logic mem_read_i,
  output logic [`WORD_W-1:0] mem_data_o,
  // Interrupt source
  input wire logic req_i,
  input wire logic service_i,
  output logic int_pending_o
);
  logic [`WORD_W-1:0] word;
  logic [`WORD_W-1:0] last_q = 16'h0000;
  logic pend_q = 1'h0;

  // ----------------------------------------
  // Program image
  // ----------------------------------------
  always_comb begin
    case (mem_addr_i)
      16'h0001: word = {1'h0, `OP_PUSHR, `OP_STA, `OP_DROP};
      16'h0002: word = {1'h0, `OP_NOP, 5'h00, 5'h00};
      default: word = 16'h0000;
    endcase
  end

  // Idle bus toggles, so a fetch outside slot zero reads garbage
  assign mem_data_o = mem_read_i ? word : ~last_q;
  always_ff @(posedge clk_i) begin
    last_q <= mem_data_o;
  end

  // ----------------------------------------
  // Interrupt source
  // ----------------------------------------
  // Request stays up until the core services it
  always_ff @(posedge clk_i) begin
    if (service_i) begin
      pend_q <= 1'h0;
    end else if (req_i) begin
      pend_q <= 1'h1;
    end
  end
  assign int_pending_o = pend_q;
endmodule

// file: bench/slot_sequencer_stack_control_tb.sv
`timescale 1ns/1ps
`include "stack_ctl_defines.svh"

module slot_sequencer_stack_control_tb;
  typedef struct {
    logic [4:0] st;
    logic [16:0] tv, rv;
    logic [1:0] slot;
    logic [16:0] t, s, r, a, rs;
  } row_t;

  // Strobes: tload, rload, spush, spop, rpush
  row_t rows [10] = '{
    '{5'h18, 17'h11, 17'h55, 2'h2, 17'h11, 17'h0, 17'h55, 17'h0, 17'h0},
    '{5'h1D, 17'h22, 17'h66, 2'h3, 17'h22, 17'h11, 17'h66, 17'h0, 17'h55},
    '{5'h16, 17'h33, 17'h0, 2'h0, 17'h33, 17'h22, 17'h66, 17'h0, 17'h55},
    '{5'h1F, 17'h1FFFF, 17'h1FFFF, 2'h1, 17'h33, 17'h22, 17'h66, 17'h0, 17'h55},
    '{5'h00, 17'h0, 17'h0, 2'h2, 17'h22, 17'h11, 17'h33, 17'h0, 17'h66},
    '{5'h00, 17'h0, 17'h0, 2'h3, 17'h11, 17'h0, 17'h33, 17'h22, 17'h66},
    '{5'h00, 17'h0, 17'h0, 2'h0, 17'h0, 17'h0, 17'h33, 17'h22, 17'h66},
    '{5'h00, 17'h0, 17'h0, 2'h1, 17'h0, 17'h0, 17'h33, 17'h22, 17'h66},
    '{5'h00, 17'h0, 17'h0, 2'h0, 17'h0, 17'h0, 17'h33, 17'h22, 17'h66},
    '{5'h00, 17'h0, 17'h0, 2'h1, 17'h0, 17'h0, 17'h33, 17'h22, 17'h66}
  };

  logic clk_i = 1'h0, rst_i = 1'h1, clr_i = 1'h1;
  logic cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, rd_q;
  logic ack_o, mem_read_o, int_pending_i, int_service_o, int_req = 1'h0;
  logic [15:0] mem_data_i, mem_addr_o, pc_v;
  logic ext_tload_i = 1'h0, ext_rload_i = 1'h0, ext_spush_i = 1'h0, ext_spop_i = 1'h0;
  logic ext_rpush_i = 1'h0, ext_rpop_i = 1'h0, ext_restart_i = 1'h0;
  logic ext_aload_i = 1'h0, ext_pload_i = 1'h0;
  logic int_load_i = 1'h0, int_set_i = 1'h0;
  logic [16:0] ext_t_in_i = 17'h0, ext_r_in_i = 17'h0;
  logic [16:0] top_o, second_o, ret_o, ret_stack_o, addr_o;
  logic [4:0] opcode_o;
  logic [1:0] slot_o, hold_v;
  logic [86:0] seen_v, exp_v;
  row_t e;
  int fail_count = 0, check_count = 0, n;

  always #5 clk_i = ~clk_i;

  slot_sequencer_stack_control i_slot_sequencer_stack_control (
    .clk_i(clk_i), .rst_i(rst_i), .clr_i(clr_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .mem_data_i(mem_data_i), .mem_addr_o(mem_addr_o), .mem_read_o(mem_read_o),
    .int_pending_i(int_pending_i), .int_service_o(int_service_o),
    .ext_tload_i(ext_tload_i), .ext_t_in_i(ext_t_in_i),
    .ext_rload_i(ext_rload_i), .ext_r_in_i(ext_r_in_i),
    .ext_aload_i(ext_aload_i), .ext_a_in_i(17'h00ABC), .ext_pload_i(ext_pload_i),
    .ext_p_in_i(16'h0100),
    .ext_spush_i(ext_spush_i), .ext_spop_i(ext_spop_i),
    .ext_rpush_i(ext_rpush_i), .ext_rpop_i(ext_rpop_i), .ext_restart_i(ext_restart_i),
    .int_load_i(int_load_i), .int_set_i(int_set_i),
    .opcode_o(opcode_o), .slot_o(slot_o), .top_o(top_o), .second_o(second_o),
    .ret_o(ret_o), .ret_stack_o(ret_stack_o), .addr_o(addr_o)
  );

  prog_mem_model i_prog_mem_model (
    .clk_i(clk_i), .mem_addr_i(mem_addr_o), .mem_read_i(mem_read_o),
    .mem_data_o(mem_data_i), .req_i(int_req), .service_i(int_service_o),
    .int_pending_o(int_pending_i)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic results();
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [86:0] seen, input logic [86:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick_out();
    n++;
    if (n > 40) begin
      fail_count++;
      results();
    end else begin
      @(negedge clk_i);
    end
  endtask

  // Entered just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    @(negedge clk_i);
    while (ack_o !== 1'h1) tick_out();
    // Ack stands through the next rising edge: take data and release there
    @(posedge clk_i);
    rd_q = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge clk_i);
  endtask

  task automatic wait_slot(input logic [1:0] v);
    n = 0;
    @(negedge clk_i);
    while (slot_o !== v) tick_out();
    @(posedge clk_i);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    clr_i <= 1'h0;
    rst_i <= 1'h0;
    @(negedge clk_i);
    chk({mem_read_o, mem_addr_o}, {1'h1, 16'h0000});
    @(posedge clk_i);
    for (int k = 0; k <= 10; k++) begin
      if (k < 10) begin
        {ext_tload_i, ext_rload_i, ext_spush_i, ext_spop_i, ext_rpush_i} <= rows[k].st;
        ext_t_in_i <= rows[k].tv;
        ext_r_in_i <= rows[k].rv;
      end else begin
        {ext_tload_i, ext_rload_i, ext_spush_i, ext_spop_i, ext_rpush_i} <= 5'h00;
      end
      @(negedge clk_i);
      if (k == 0) begin
        chk({slot_o, mem_addr_o}, {2'h1, 16'h0001});
      end else begin
        e = rows[k-1];
        seen_v = {slot_o, top_o, second_o, ret_o, addr_o, ret_stack_o};
        exp_v = {e.slot, e.t, e.s, e.r, e.a, e.rs};
        chk(seen_v, exp_v);
        if (k == 4) chk(opcode_o, `OP_PUSHR);
      end
      @(posedge clk_i);
    end
    wb(1'h0, `REG_STATUS, 32'h0);
    chk(rd_q[11:2], {5'h02, 5'h1F});
    wb(1'h0, `REG_RET, 32'h0);
    chk(rd_q, 32'h33);
    wb(1'h0, 8'h40, 32'h0);
    chk(rd_q, 32'h0);
    // Halted core must not step its slots
    wb(1'h1, `REG_CTRL, 32'h0);
    @(negedge clk_i);
    hold_v = slot_o;
    repeat (3) @(negedge clk_i);
    chk(slot_o, hold_v);
    @(posedge clk_i);
    wb(1'h1, `REG_CTRL, 32'h1);
    wait_slot(2'h1);
    ext_rpop_i <= 1'h1;
    ext_aload_i <= 1'h1;
    ext_pload_i <= 1'h1;
    @(posedge clk_i);
    ext_rpop_i <= 1'h0;
    ext_aload_i <= 1'h0;
    ext_pload_i <= 1'h0;
    @(negedge clk_i);
    chk({ret_stack_o, addr_o, mem_addr_o}, {17'h55, 17'h00ABC, 16'h0100});
    wait_slot(2'h1);
    ext_restart_i <= 1'h1;
    @(posedge clk_i);
    ext_restart_i <= 1'h0;
    @(negedge clk_i);
    chk(slot_o, 2'h0);
    wait_slot(2'h1);
    int_load_i <= 1'h1;
    int_set_i <= 1'h1;
    @(posedge clk_i);
    int_load_i <= 1'h0;
    int_req <= 1'h1;
    @(posedge clk_i);
    int_req <= 1'h0;
    n = 0;
    @(negedge clk_i);
    while (int_service_o !== 1'h1) tick_out();
    pc_v = mem_addr_o;
    chk(mem_read_o, 1'h0);
    @(negedge clk_i);
    chk({slot_o, mem_addr_o, ret_o, ret_stack_o}, {2'h1, `INT_VECTOR, 1'h0, pc_v, 17'h33});
    // Master clear in mid-run
    @(posedge clk_i);
    clr_i <= 1'h1;
    @(negedge clk_i);
    chk({slot_o, top_o, second_o, ret_o, addr_o, ret_stack_o}, 87'h0);
    @(posedge clk_i);
    clr_i <= 1'h0;
    @(negedge clk_i);
    chk({mem_read_o, mem_addr_o}, {1'h1, 16'h0000});
    @(negedge clk_i);
    chk({slot_o, mem_addr_o}, {2'h1, 16'h0001});
    @(posedge clk_i);
    wb(1'h0, `REG_STATUS, 32'h0);
    chk(rd_q[13:2], 12'h000);
    results();
  end
endmodule

// file: hw/slot_counter.sv
`timescale 1ns/1ps
`include "stack_ctl_defines.svh"

module slot_counter (
  // Clock and master clear
  input wire logic clk_i,
  input wire logic clr_i,
  // Control
  input wire logic en_i,
  input wire logic restart_i,
  // Phase
  output stack_ctl_pkg::phase_t phase_o
);

  stack_ctl_pkg::phase_t phase_q;
  stack_ctl_pkg::phase_t phase_d;

  always_comb begin
    phase_d = phase_q;
    if (en_i) begin
      if (restart_i) begin
        phase_d = stack_ctl_pkg::PH0;
      end else begin
        case (phase_q)
          stack_ctl_pkg::PH0: phase_d = stack_ctl_pkg::PH1;
          stack_ctl_pkg::PH1: phase_d = stack_ctl_pkg::PH2;
          stack_ctl_pkg::PH2: phase_d = stack_ctl_pkg::PH3;
          stack_ctl_pkg::PH3: phase_d = stack_ctl_pkg::PH0;
          default: phase_d = stack_ctl_pkg::PH0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or posedge clr_i) begin
    if (clr_i) begin
      phase_q <= stack_ctl_pkg::PH0;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign phase_o = phase_q;

endmodule

// file: hw/slot_sequencer_stack_control.sv
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "stack_ctl_defines.svh"

// How it works
// - PUSHR: push R, R<=T, T<=S, pop.
// - STA: A<=T, T<=S, pop parameter stack.
// - NOP restarts slots at slot zero.
// - DROP: T<=S and pop parameter stack.
// - Phase counter steps zero to three, wraps.
// - Phase clears after three or restart strobe.
// - Slot zero services interrupt, else fetches.
// - Master clear zeroes all but the Wishbone side (run bit, ack, read data); auxiliaries become one.
// - After clear fetch word zero, then slot one.
// - Interrupt enable loads set value when strobed.
// - Instruction register latches memory data when strobed.
// - P, T, R, A load only when strobed.
// - Two stacks, 32 by 17, single cycle.
// - Auxiliary pointer always principal plus one.
// - Parameter push writes at auxiliary; push wins.
// - Parameter pop reads principal, then decrements.
// - Return push writes at auxiliary; push wins.
// - Return pop reads principal, then decrements.

module slot_sequencer_stack_control (
  // Clock, bus reset, master clear
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Program memory
  input wire logic [`WORD_W-1:0] mem_data_i,
  output logic [`WORD_W-1:0] mem_addr_o,
  output logic mem_read_o,
  // Interrupt source pin
  input wire logic int_pending_i,
  output logic int_service_o,
  // External decode strobes and mux outputs
  input wire logic ext_tload_i,
  input wire logic [`CELL_W-1:0] ext_t_in_i,
  input wire logic ext_rload_i,
  input wire logic [`CELL_W-1:0] ext_r_in_i,
  input wire logic ext_aload_i,
  input wire logic [`CELL_W-1:0] ext_a_in_i,
  input wire logic ext_pload_i,
  input wire logic [`WORD_W-1:0] ext_p_in_i,
  input wire logic ext_spush_i,
  input wire logic ext_spop_i,
  input wire logic ext_rpush_i,
  input wire logic ext_rpop_i,
  input wire logic ext_restart_i,
  input wire logic int_load_i,
  input wire logic int_set_i,
  // Datapath view for the external decode
  output logic [`OP_W-1:0] opcode_o,
  output logic [1:0] slot_o,
  output logic [`CELL_W-1:0] top_o,
  output logic [`CELL_W-1:0] second_o,
  output logic [`CELL_W-1:0] ret_o,
  output logic [`CELL_W-1:0] ret_stack_o,
  output logic [`CELL_W-1:0] addr_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [`PTR_W-1:0] ptr_step(input logic [`PTR_W-1:0] p,
                                                 input logic up, input logic dn);
    if (up) begin
      ptr_step = p + `PTR_W'(1);
    end else if (dn) begin
      ptr_step = p - `PTR_W'(1);
    end else begin
      ptr_step = p;
    end
  endfunction

  function automatic logic [`OP_W-1:0] slot_op(input logic [`WORD_W-1:0] w,
                                               input logic [1:0] s);
    case (s)
      2'h1: slot_op = w[14:10];
      2'h2: slot_op = w[9:5];
      2'h3: slot_op = w[4:0];
      default: slot_op = '0;
    endcase
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [`CELL_W-1:0] t_q, r_q, a_q;
  logic [`WORD_W-1:0] p_q, i_q;
  logic inten_q;
  logic [`PTR_W-1:0] param_pointer_q, param_pointer_plus_one_q;
  logic [`PTR_W-1:0] return_pointer_q, return_pointer_plus_one_q;
  logic run_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic pend_s1_q, pend_s2_q, pend_s3_q, pend_q;
  stack_ctl_pkg::phase_t phase;
  logic [`CELL_W-1:0] second, ret_top;

  // ----------------------------------------
  // Interrupt pin synchroniser
  // ----------------------------------------
  // Filtered level only moves when stages two and three agree
  always_ff @(posedge clk_i or posedge clr_i) begin
    if (clr_i) begin
      pend_s1_q <= 1'b0;
      pend_s2_q <= 1'b0;
      pend_s3_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      pend_s1_q <= int_pending_i;
      pend_s2_q <= pend_s1_q;
      pend_s3_q <= pend_s2_q;
      if (pend_s2_q == pend_s3_q) begin
        pend_q <= pend_s3_q;
      end
    end
  end

  // ----------------------------------------
  // Slot decode
  // ----------------------------------------
  wire [1:0] slot = phase;
  wire slot0 = (phase == stack_ctl_pkg::PH0);
  wire service = run_q && slot0 && pend_q && inten_q;
  wire fetch = run_q && slot0 && !service;
  wire exec = run_q && !slot0;
  wire [`OP_W-1:0] op = slot_op(i_q, slot);
  wire is_pushr = exec && (op == `OP_PUSHR);
  wire is_sta = exec && (op == `OP_STA);
  wire is_nop = exec && (op == `OP_NOP);
  wire is_drop = exec && (op == `OP_DROP);
  wire own_t = is_pushr || is_sta || is_drop;

  // Strobes and mux selections
  wire tload = own_t || (exec && ext_tload_i);
  wire [`CELL_W-1:0] t_d = own_t ? second : ext_t_in_i;
  wire rload = is_pushr || service || (exec && ext_rload_i);
  wire [`CELL_W-1:0] r_d = is_pushr ? t_q :
                           service ? {1'b0, p_q} : ext_r_in_i;
  wire aload = is_sta || (exec && ext_aload_i);
  wire [`CELL_W-1:0] a_d = is_sta ? t_q : ext_a_in_i;
  wire pload = fetch || service || (exec && ext_pload_i);
  wire [`WORD_W-1:0] p_d = fetch ? p_q + `WORD_W'(1) :
                           service ? `INT_VECTOR : ext_p_in_i;
  wire iload = fetch;
  wire intload = service || (exec && int_load_i);
  wire intset = service ? 1'b0 : int_set_i;
  wire spush = exec && ext_spush_i;
  wire spop = own_t || (exec && ext_spop_i);
  wire rpush = is_pushr || service || (exec && ext_rpush_i);
  wire rpop = exec && ext_rpop_i;
  wire restart = is_nop || (exec && ext_restart_i);

  // ----------------------------------------
  // Phase counter
  // ----------------------------------------
  slot_counter u_slot (
    .clk_i(clk_i),
    .clr_i(clr_i),
    .en_i(run_q),
    .restart_i(restart),
    .phase_o(phase)
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge clr_i) begin
    if (clr_i) begin
      t_q <= '0;
      r_q <= '0;
      a_q <= '0;
      p_q <= '0;
      i_q <= '0;
      inten_q <= 1'b0;
    end else begin
      if (tload) t_q <= t_d;
      if (rload) r_q <= r_d;
      if (aload) a_q <= a_d;
      if (pload) p_q <= p_d;
      if (iload) i_q <= mem_data_i;
      if (intload) inten_q <= intset;
    end
  end

  // ----------------------------------------
  // Stack pointers
  // ----------------------------------------
  // Push beats pop; both pointers always move together
  wire [`PTR_W-1:0] pp_d = ptr_step(param_pointer_q, spush, spop);
  wire [`PTR_W-1:0] pp1_d = ptr_step(param_pointer_plus_one_q, spush, spop);
  wire [`PTR_W-1:0] rp_d = ptr_step(return_pointer_q, rpush, rpop);
  wire [`PTR_W-1:0] rp1_d = ptr_step(return_pointer_plus_one_q, rpush, rpop);

  always_ff @(posedge clk_i or posedge clr_i) begin
    if (clr_i) begin
      param_pointer_q <= `PTR_RESET;
      param_pointer_plus_one_q <= `PTR1_RESET;
      return_pointer_q <= `PTR_RESET;
      return_pointer_plus_one_q <= `PTR1_RESET;
    end else begin
      param_pointer_q <= pp_d;
      param_pointer_plus_one_q <= pp1_d;
      return_pointer_q <= rp_d;
      return_pointer_plus_one_q <= rp1_d;
    end
  end

  // ----------------------------------------
  // Stack arrays
  // ----------------------------------------
  stack_ram u_param_stack (
    .clk_i(clk_i),
    .clr_i(clr_i),
    .wr_en_i(spush),
    .wr_addr_i(param_pointer_plus_one_q),
    .wr_data_i(t_q),
    .rd_addr_i(pp_d),
    .rd_data_o(second)
  );

  stack_ram u_return_stack (
    .clk_i(clk_i),
    .clr_i(clr_i),
    .wr_en_i(rpush),
    .wr_addr_i(return_pointer_plus_one_q),
    .wr_data_i(r_q),
    .rd_addr_i(rp_d),
    .rd_data_o(ret_top)
  );

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  wire req = cyc_i && stb_i && !ack_q;
  // Write lands on the edge at which the master sees ack high
  wire ctrl_wr = cyc_i && stb_i && ack_q && we_i && sel_i[0] && (adr_i == `REG_CTRL);
  wire [31:0] status = {18'h0, pend_q, inten_q, return_pointer_q, param_pointer_q,
                        slot};
  wire [31:0] rd_mux = (adr_i == `REG_CTRL) ? {31'h0, run_q} :
                       (adr_i == `REG_STATUS) ? status :
                       (adr_i == `REG_TOP) ? {15'h0, t_q} :
                       (adr_i == `REG_SECOND) ? {15'h0, second} :
                       (adr_i == `REG_RET) ? {15'h0, r_q} :
                       (adr_i == `REG_ADDR) ? {15'h0, a_q} :
                       (adr_i == `REG_PC) ? {16'h0, p_q} :
                       (adr_i == `REG_INSTR) ? {16'h0, i_q} : 32'h0;

  // Run bit gates the whole sequencer so software can freeze and inspect it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= `CTRL_RESET;
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= req;
      if (req) dat_q <= rd_mux;
      if (ctrl_wr) run_q <= dat_i[`CTRL_RUN_BIT];
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign mem_addr_o = p_q;
  assign mem_read_o = fetch;
  assign int_service_o = service;
  assign opcode_o = op;
  assign slot_o = slot;
  assign top_o = t_q;
  assign second_o = second;
  assign ret_o = r_q;
  assign ret_stack_o = ret_top;
  assign addr_o = a_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (clr_i);

  // An external push in the same slot outranks the pop of the own ops
  pushr_effect_a: assert property (
    is_pushr && !ext_spush_i |=> t_q == $past(second) && r_q == $past(t_q)
      && return_pointer_q == $past(return_pointer_q) + 5'h01
      && param_pointer_q == $past(param_pointer_q) - 5'h01)
    else $error("pushr did not move registers and stacks");

  sta_effect_a: assert property (
    is_sta && !ext_spush_i |=> a_q == $past(t_q) && t_q == $past(second)
      && param_pointer_q == $past(param_pointer_q) - 5'h01)
    else $error("sta did not load address register");

  nop_restart_a: assert property (
    is_nop |=> phase == stack_ctl_pkg::PH0)
    else $error("nop did not restart slot");

  drop_effect_a: assert property (
    is_drop && !ext_spush_i |=> t_q == $past(second)
      && param_pointer_q == $past(param_pointer_q) - 5'h01)
    else $error("drop did not pop");

  slot_step_a: assert property (
    run_q && !restart && phase != stack_ctl_pkg::PH3
      |=> slot == $past(slot) + 2'h1)
    else $error("slot did not advance");

  slot_wrap_a: assert property (
    run_q && phase == stack_ctl_pkg::PH3 |=> phase == stack_ctl_pkg::PH0)
    else $error("slot did not wrap");

  // Slot one follows every fetch, whatever the fetched word holds
  fetch_latch_a: assert property (
    fetch |=> i_q == $past(mem_data_i) && p_q == $past(p_q) + 16'h0001
      && phase == stack_ctl_pkg::PH1)
    else $error("fetch did not latch word");

  service_entry_a: assert property (
    service |=> p_q == `INT_VECTOR && r_q == {1'b0, $past(p_q)} && !inten_q
      && phase == stack_ctl_pkg::PH1)
    else $error("interrupt entry not taken");

  inten_load_a: assert property (
    exec && int_load_i && !service |=> inten_q == $past(int_set_i))
    else $error("interrupt enable not loaded");

  top_hold_a: assert property (
    !tload |=> $stable(t_q))
    else $error("top changed without strobe");

  aux_ptr_a: assert property (
    param_pointer_plus_one_q == param_pointer_q + 5'h01
      && return_pointer_plus_one_q == return_pointer_q + 5'h01)
    else $error("auxiliary pointer out of step");

  push_wins_a: assert property (
    spush && spop |=> param_pointer_q == $past(param_pointer_q) + 5'h01)
    else $error("push did not win over pop");

  service_c: cover property (service);
  pushr_c: cover property (is_pushr ##1 is_drop);
  wrap_c: cover property (param_pointer_q == 5'h1F ##1 param_pointer_q == 5'h00);
  restart_c: cover property (exec && ext_restart_i);
  halt_c: cover property (!run_q ##1 run_q);

endmodule

// file: hw/stack_ctl_defines.svh
`ifndef STACK_CTL_DEFINES_SVH
`define STACK_CTL_DEFINES_SVH

// ----------------------------------------
// Datapath geometry
// ----------------------------------------
`define WORD_W 16
`define CELL_W 17
`define PTR_W 5
`define STACK_DEPTH 32
`define OP_W 5

// ----------------------------------------
// Pointer reset values
// ----------------------------------------
`define PTR_RESET 5'h00
`define PTR1_RESET 5'h01

// ----------------------------------------
// Slot opcodes handled here (arbitrary encodings)
// ----------------------------------------
`define OP_PUSHR 5'h14
`define OP_STA 5'h15
`define OP_NOP 5'h1E
`define OP_DROP 5'h1C

// ----------------------------------------
// Interrupt service entry address (arbitrary)
// ----------------------------------------
`define INT_VECTOR 16'h0002

// ----------------------------------------
// Wishbone register map, byte addresses
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_TOP 8'h08
`define REG_SECOND 8'h0C
`define REG_RET 8'h10
`define REG_ADDR 8'h14
`define REG_PC 8'h18
`define REG_INSTR 8'h1C

// ----------------------------------------
// Register fields
// ----------------------------------------
`define CTRL_RUN_BIT 0
`define CTRL_RESET 1'h1
`define ST_SLOT_LSB 0
`define ST_PP_LSB 2
`define ST_RP_LSB 7
`define ST_INTEN_BIT 12
`define ST_INTPEND_BIT 13

`endif

// file: hw/stack_ctl_pkg.sv
package stack_ctl_pkg;

  typedef enum logic [1:0] {
    PH0,
    PH1,
    PH2,
    PH3
  } phase_t;

endpackage

// file: hw/stack_ram.sv
`timescale 1ns/1ps
`include "stack_ctl_defines.svh"

module stack_ram (
  // Clock and master clear
  input wire logic clk_i,
  input wire logic clr_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [`PTR_W-1:0] wr_addr_i,
  input wire logic [`CELL_W-1:0] wr_data_i,
  // Read port, address of next cycle's top
  input wire logic [`PTR_W-1:0] rd_addr_i,
  output logic [`CELL_W-1:0] rd_data_o
);

  logic [`CELL_W-1:0] mem_q [`STACK_DEPTH];
  logic [`CELL_W-1:0] rd_q;
  wire fwd = wr_en_i && (wr_addr_i == rd_addr_i);

  // Read data registered one cycle ahead so the pop operand is ready at once
  always_ff @(posedge clk_i or posedge clr_i) begin
    if (clr_i) begin
      for (int k = 0; k < `STACK_DEPTH; k++) begin
        mem_q[k] <= '0;
      end
      rd_q <= '0;
    end else begin
      if (wr_en_i) begin
        mem_q[wr_addr_i] <= wr_data_i;
      end
      rd_q <= fwd ? wr_data_i : mem_q[rd_addr_i];
    end
  end

  assign rd_data_o = rd_q;

endmodule
